/* common/ledser_pkg.sv */
// Constants for the LED status and serial LED output block.
// Assumes one 100 MHz core clock and a separate link-side clock.
// How it works
// - LED0 of port 0 with mode code 0xD selects basic serial mode.
// - Basic serial: LED0 port 0 is data, LED1 clock, others normal.
// - Basic serial data is valid for the rising serial clock edge.
// - Serial bits use each port's LED0 combine and blink settings.
// - Basic frame is 24 bits, twelve per port in fixed order.
// - Enhanced mode: port pins are data, shift clock, latch, dim pulse.
// - Enhanced data changes on falling shift clock; converter samples rising.
// - Global LED config bits 2:1 select enhanced pin function.
// - Dim pulse is 5 kHz, duty from global config bits 15:8.
// - Extended control bits 13:12 enable extended modes on LED0.
// - Mode 20 off, 21 on without pulsing, 22 fast link failure.
// - Global config bit 0 swaps ports of direct LEDs only.
// - Combine shows primary plus secondary activity; else primary only, or activity in secondary-only modes.
// - Blink is 50 percent; stretch holds each state a minimum period.
// - Rates 2.5 to 20 Hz, 50 to 400 ms, one global selection.
// - Pulsing enable gates asserted LEDs at 5 kHz, 20 percent.
// - Extended bit 11 blinks LEDs one second after hold or reset.
// - Fast link-down pin follows failure within 3 ms.
// - Interrupt for fast link failure only at 1000 and 100 speeds; the logic suppresses it only at 10, so it also rises with no speed up.
// - Failure is link status bit, or integrity monitor at 1000.
// - Interrupt stays asserted until management clears its status.
package ledser_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  // Mode codes
  localparam logic [3:0] MODE_SERIAL = 4'hd;
  localparam logic [3:0] MODE_OFF = 4'he;
  localparam logic [3:0] EXT_OFF = 4'h4;
  localparam logic [3:0] EXT_ON = 4'h5;
  localparam logic [3:0] EXT_FLF = 4'h6;
  localparam logic [4:0] MT_RSV = 5'h07;
  localparam logic [4:0] MT_TX = 5'h10;
  localparam logic [4:0] MT_RX = 5'h11;
  // Serial frame order, first shifted first
  localparam logic [4:0] SER_ORDER [12] = '{5'h00, 5'h01, 5'h02, 5'h03, MT_RSV,
    5'h08, 5'h09, 5'h0a, MT_RSV, MT_TX, MT_RX, 5'h0c};
  localparam int unsigned PORT_BITS = 12;
  localparam logic [4:0] FRAME_BASIC = 5'h18;
  localparam logic [4:0] FRAME_ENH = 5'h04;
  // Status vector layout
  localparam int unsigned ST_1000 = 0;
  localparam int unsigned ST_100 = 1;
  localparam int unsigned ST_10 = 2;
  localparam int unsigned ST_FDX = 3;
  localparam int unsigned ST_COLL = 4;
  localparam int unsigned ST_TX = 5;
  localparam int unsigned ST_RX = 6;
  localparam int unsigned ST_ANEG = 7;
  localparam int unsigned ST_FLF = 8;
  localparam int unsigned ST_W = 9;
  // Configuration field positions
  localparam int unsigned GCFG_SWAP = 0;
  localparam int unsigned GCFG_ENH_LSB = 1;
  localparam int unsigned GCFG_DUTY_LSB = 8;
  localparam int unsigned EXT_BLINK_RST = 11;
  localparam int unsigned EXT_EN_LSB = 12;
  // Timing
  localparam int unsigned TICK_US = 25_000;
  localparam int unsigned TICK_CYC = TICK_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BAR_MS = 1000;
  localparam int unsigned BAR_CYC = BAR_MS * (CLK_HZ / 1000);
  localparam int unsigned PULSE_HZ = 5000;
  localparam int unsigned PULSE_CYC = CLK_HZ / PULSE_HZ;
  localparam int unsigned PULSE_ON_PCT = 20;
  localparam int unsigned SHIFT_HZ = 1_000_000;
  localparam int unsigned SHIFT_HALF_CYC = CLK_HZ / (2 * SHIFT_HZ);
endpackage : ledser_pkg

/* rtl/ledser_top.sv */
// LED indication logic: direct pins, basic and enhanced serial streams,
// fast link failure pin and interrupt flag.
// Assumes status inputs come from link logic on linkClk, configuration
// and strobes from management logic on clk, lowPowerHold from a pin.
`timescale 1ns/10ps
module ledser_top #(
  parameter int unsigned TICK_CYC = ledser_pkg::TICK_CYC,
  parameter int unsigned BAR_CYC = ledser_pkg::BAR_CYC,
  parameter int unsigned PULSE_CYC = ledser_pkg::PULSE_CYC,
  parameter int unsigned SHIFT_HALF_CYC = ledser_pkg::SHIFT_HALF_CYC
) (
  // Clocks and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic linkClk,
  // Link status per port, linkClk domain
  input wire logic [1:0] linkUp1000,
  input wire logic [1:0] linkUp100,
  input wire logic [1:0] linkUp10,
  input wire logic [1:0] fullDuplex,
  input wire logic [1:0] collision,
  input wire logic [1:0] txActivity,
  input wire logic [1:0] rxActivity,
  input wire logic [1:0] anegFault,
  input wire logic [1:0] linkIntegrityOk,
  input wire logic [1:0] linkStatusBit,
  // Configuration, clk domain
  input wire logic [31:0] ledMode,
  input wire logic [7:0] ledCombineEn,
  input wire logic [7:0] ledBlinkSel,
  input wire logic [1:0] ledRateSel,
  input wire logic ledPulsingEn,
  input wire logic [15:0] globalLedConfig,
  input wire logic [15:0] extendedLedControl,
  input wire logic intPinEnable,
  input wire logic [1:0] intStatusClear,
  input wire logic softReset,
  // Pin input
  input wire logic lowPowerHold,
  // Outputs
  output logic [7:0] ledOut,
  output logic [1:0] fastLinkDownOut,
  output logic [1:0] fastLinkFailure,
  output logic [1:0] mgmtInterruptNOut,
  output logic [1:0] mgmtInterruptNOe
);
  localparam int unsigned SW = ledser_pkg::ST_W;
  localparam int unsigned TW = $clog2(TICK_CYC);
  localparam int unsigned BW = $clog2(BAR_CYC + 1);
  localparam int unsigned PW = $clog2(PULSE_CYC);
  localparam int unsigned DW = $clog2(SHIFT_HALF_CYC);
  localparam int unsigned PULSE_ON = PULSE_CYC * ledser_pkg::PULSE_ON_PCT / 100;

  // {pri, sec, secOnly} for a display function
  function automatic logic [2:0] modeTerms(input logic [4:0] m, input logic [SW-1:0] s);
    logic lk;
    logic act;
    lk = s[ledser_pkg::ST_1000] | s[ledser_pkg::ST_100] | s[ledser_pkg::ST_10];
    act = s[ledser_pkg::ST_TX] | s[ledser_pkg::ST_RX];
    case (m)
      5'h00: modeTerms = {lk, lk & act, 1'b0};
      5'h01: modeTerms = {s[ledser_pkg::ST_1000], s[ledser_pkg::ST_1000] & act, 1'b0};
      5'h02: modeTerms = {s[ledser_pkg::ST_100], s[ledser_pkg::ST_100] & act, 1'b0};
      5'h03: modeTerms = {s[ledser_pkg::ST_10], s[ledser_pkg::ST_10] & act, 1'b0};
      5'h04: modeTerms = {s[ledser_pkg::ST_100] | s[ledser_pkg::ST_1000],
                          (s[ledser_pkg::ST_100] | s[ledser_pkg::ST_1000]) & act, 1'b0};
      5'h05: modeTerms = {s[ledser_pkg::ST_10] | s[ledser_pkg::ST_1000],
                          (s[ledser_pkg::ST_10] | s[ledser_pkg::ST_1000]) & act, 1'b0};
      5'h06: modeTerms = {s[ledser_pkg::ST_10] | s[ledser_pkg::ST_100],
                          (s[ledser_pkg::ST_10] | s[ledser_pkg::ST_100]) & act, 1'b0};
      5'h08: modeTerms = {lk & s[ledser_pkg::ST_FDX],
                          lk & ~s[ledser_pkg::ST_FDX] & s[ledser_pkg::ST_COLL], 1'b0};
      5'h09: modeTerms = {1'b0, s[ledser_pkg::ST_COLL], 1'b1};
      5'h0a: modeTerms = {1'b0, act, 1'b1};
      5'h0c: modeTerms = {s[ledser_pkg::ST_ANEG], 1'b0, 1'b0};
      5'h0f: modeTerms = 3'h4;
      5'h10: modeTerms = {1'b0, s[ledser_pkg::ST_TX], 1'b1};
      5'h11: modeTerms = {1'b0, s[ledser_pkg::ST_RX], 1'b1};
      default: modeTerms = 3'h0;
    endcase
  endfunction : modeTerms

  // Primary level shaped by secondary activity
  function automatic logic shapeLed(input logic [2:0] t, input logic secS, input logic comb,
                                    input logic bsel, input logic blinkPh);
    if (!(comb | t[0])) return t[2];
    if (bsel) return t[1] ? blinkPh : t[2];
    return t[2] ^ secS;
  endfunction : shapeLed

  function automatic logic pinLevel(input logic [3:0] m, input logic ext,
                                    input logic [SW-1:0] s, input logic [SW-1:0] ss,
                                    input logic comb, input logic bsel, input logic blinkPh,
                                    input logic bar, input logic pOn, input logic pEn);
    logic lvl;
    logic [2:0] ts;
    ts = modeTerms({1'b0, m}, ss);
    lvl = shapeLed(modeTerms({1'b0, m}, s), ts[1], comb, bsel, blinkPh);
    if (ext) begin
      if (m == ledser_pkg::EXT_ON) lvl = 1'b1;
      else if (m == ledser_pkg::EXT_FLF) lvl = s[ledser_pkg::ST_FLF];
      else lvl = 1'b0;
    end
    if (bar && !ext && m < ledser_pkg::MODE_OFF) lvl = blinkPh;
    if (pEn && !(ext && m == ledser_pkg::EXT_ON)) lvl = lvl & pOn;
    return lvl;
  endfunction : pinLevel

  // Link domain: status capture and failure detection
  logic [1:0][SW-1:0] stLnk_q;
  wire [1:0] flfRaw = (linkUp1000 & ~linkIntegrityOk) | (~linkUp1000 & ~linkStatusBit);
  always_ff @(posedge linkClk or negedge nrst) begin
    if (!nrst) begin
      stLnk_q <= '0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        stLnk_q[p] <= {flfRaw[p], anegFault[p], rxActivity[p], txActivity[p], collision[p],
                       fullDuplex[p], linkUp10[p], linkUp100[p], linkUp1000[p]};
      end
    end
  end

  // Crossing into clk: independent slow levels, two flops each
  logic [1:0][SW-1:0] stMeta_q;
  logic [1:0][SW-1:0] st_q;
  logic holdMeta_q;
  logic hold_q;
  logic holdPrev_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stMeta_q <= '0;
      st_q <= '0;
      holdMeta_q <= 1'b0;
      hold_q <= 1'b0;
      holdPrev_q <= 1'b0;
    end else begin
      stMeta_q <= stLnk_q;
      st_q <= stMeta_q;
      holdMeta_q <= lowPowerHold;
      hold_q <= holdMeta_q;
      holdPrev_q <= hold_q;
    end
  end

  // Rate timebase: one tick per 25 ms
  logic [TW-1:0] tickCnt_q;
  logic [3:0] blinkCnt_q;
  wire tick = tickCnt_q == TW'(TICK_CYC - 1);
  wire blinkPh = blinkCnt_q[ledRateSel];
  wire [4:0] stretchLen = 5'h02 << ledRateSel;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tickCnt_q <= '0;
      blinkCnt_q <= 4'h0;
    end else begin
      tickCnt_q <= tick ? '0 : tickCnt_q + TW'(1);
      blinkCnt_q <= blinkCnt_q + {3'h0, tick};
    end
  end

  // Pulse stretchers for collision, tx and rx per port
  logic [1:0][2:0] str_q;
  logic [1:0][2:0][4:0] strT_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      str_q <= '0;
      strT_q <= '0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        for (int i = 0; i < 3; i++) begin
          if (strT_q[p][i] != 5'h00) begin
            strT_q[p][i] <= strT_q[p][i] - {4'h0, tick};
          end else if (st_q[p][ledser_pkg::ST_COLL + i] != str_q[p][i]) begin
            str_q[p][i] <= st_q[p][ledser_pkg::ST_COLL + i];
            strT_q[p][i] <= stretchLen;
          end
        end
      end
    end
  end
  wire [1:0][SW-1:0] stS = {st_q[1][8:7], str_q[1], st_q[1][3:0],
                            st_q[0][8:7], str_q[0], st_q[0][3:0]};

  // 5 kHz base for pulsing and dimming
  logic [PW-1:0] pulseCnt_q;
  wire pulseWrap = pulseCnt_q == PW'(PULSE_CYC - 1);
  wire pulseOn = pulseCnt_q < PW'(PULSE_ON);
  wire [31:0] dimProd = 32'(globalLedConfig[15:ledser_pkg::GCFG_DUTY_LSB]) * PULSE_CYC;
  wire [PW-1:0] dimThr = PW'(dimProd >> 8);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) pulseCnt_q <= '0;
    else pulseCnt_q <= pulseWrap ? '0 : pulseCnt_q + PW'(1);
  end

  // Blink window after hold release or software reset
  logic [BW-1:0] bar_q;
  wire barStart = extendedLedControl[ledser_pkg::EXT_BLINK_RST] &
                  ((holdPrev_q & ~hold_q) | softReset);
  wire barActive = bar_q != '0;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) bar_q <= '0;
    else if (barStart) bar_q <= BW'(BAR_CYC);
    else if (barActive) bar_q <= bar_q - BW'(1);
  end

  // Direct pin levels, pin n = port * 4 + led
  wire [7:0] ledDirect;
  wire [23:0] basicFrame;
  for (genvar n = 0; n < 8; n++) begin : g_pin
    wire ext = (n % 4 == 0) && extendedLedControl[ledser_pkg::EXT_EN_LSB + n / 4];
    assign ledDirect[n] = pinLevel(ledMode[4*n +: 4], ext, st_q[n/4], stS[n/4],
                                   ledCombineEn[n], ledBlinkSel[n], blinkPh, barActive,
                                   pulseOn, ledPulsingEn);
  end
  for (genvar i = 0; i < 24; i++) begin : g_ser
    localparam int unsigned P = i / ledser_pkg::PORT_BITS;
    wire [2:0] tS = modeTerms(ledser_pkg::SER_ORDER[i % ledser_pkg::PORT_BITS], stS[P]);
    assign basicFrame[i] = shapeLed(modeTerms(ledser_pkg::SER_ORDER[i % ledser_pkg::PORT_BITS],
                                              st_q[P]),
                                    tS[1], ledCombineEn[4*P], ledBlinkSel[4*P], blinkPh);
  end

  // Mode decode
  wire basicMode = ledMode[3:0] == ledser_pkg::MODE_SERIAL;
  wire [1:0] enhMode = globalLedConfig[ledser_pkg::GCFG_ENH_LSB +: 2];
  wire [4:0] frameLen = (basicMode && !enhMode[0]) ? ledser_pkg::FRAME_BASIC
                                                    : ledser_pkg::FRAME_ENH;
  wire [7:0] ledPhys = globalLedConfig[ledser_pkg::GCFG_SWAP] ?
                       {ledDirect[3:0], ledDirect[7:4]} : ledDirect;

  // Serial shifter: data moves with the falling shift clock edge
  logic [DW-1:0] div_q;
  logic phase_q;
  logic sclk_q;
  logic latch_q;
  logic [4:0] slot_q;
  logic [1:0] serData_q;
  wire halfTick = div_q == DW'(SHIFT_HALF_CYC - 1);
  wire [4:0] slotNext = (slot_q >= frameLen) ? 5'h00 : slot_q + 5'h01;
  // Next frame's first bit goes out as the latch slot starts, so the
  // clockless latch slot never moves the data line
  wire [4:0] dataSlot = (slotNext == frameLen) ? 5'h00 : slotNext;
  wire [1:0] nextBit;
  assign nextBit[0] = enhMode[0] ? ledDirect[dataSlot[1:0]] : basicFrame[dataSlot];
  assign nextBit[1] = ledDirect[3'h4 + {1'b0, dataSlot[1:0]}];
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= '0;
      phase_q <= 1'b0;
      sclk_q <= 1'b0;
      latch_q <= 1'b0;
      slot_q <= 5'h00;
      serData_q <= 2'h0;
    end else begin
      div_q <= halfTick ? '0 : div_q + DW'(1);
      if (halfTick) begin
        phase_q <= ~phase_q;
        if (phase_q) begin
          sclk_q <= 1'b0;
          slot_q <= slotNext;
          if (slotNext != 5'h00) serData_q <= nextBit;
          latch_q <= slotNext == frameLen;
        end else begin
          sclk_q <= ~latch_q;
        end
      end
    end
  end
  wire dimOn = pulseCnt_q < dimThr;

  // Pin multiplexing, registered
  wire [3:0] port0Pins = enhMode[0] ? {dimOn, latch_q, sclk_q, serData_q[0]} :
                         basicMode ? {ledPhys[3:2], sclk_q, serData_q[0]} : ledPhys[3:0];
  wire [3:0] port1Pins = enhMode[1] ? {dimOn, latch_q, sclk_q, serData_q[1]} : ledPhys[7:4];

  // Fast link failure and interrupt flag
  logic [1:0] flfPrev_q;
  logic [1:0] intFlag_q;
  wire [1:0] flfNow = {st_q[1][ledser_pkg::ST_FLF], st_q[0][ledser_pkg::ST_FLF]};
  wire [1:0] spd10 = {st_q[1][ledser_pkg::ST_10], st_q[0][ledser_pkg::ST_10]};
  wire [1:0] intSet = flfNow & ~flfPrev_q & ~spd10;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ledOut <= 8'h00;
      fastLinkDownOut <= 2'h0;
      flfPrev_q <= 2'h0;
      intFlag_q <= 2'h0;
    end else begin
      ledOut <= {port1Pins, port0Pins};
      fastLinkDownOut <= flfNow;
      flfPrev_q <= flfNow;
      intFlag_q <= intSet | (intFlag_q & ~intStatusClear);
    end
  end
  assign fastLinkFailure = intFlag_q;
  assign mgmtInterruptNOut = 2'h0;
  assign mgmtInterruptNOe = intFlag_q & {2{intPinEnable}};

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_data_edge: assert property ($changed(serData_q) |-> $fell(sclk_q))
    else $error("Serial data changed away from a falling shift clock");
  chk_latch_end: assert property ($fell(latch_q) |-> slot_q == 5'h00 && !sclk_q)
    else $error("Latch strobe ended outside frame restart");
  chk_basic_pins: assert property (basicMode && !enhMode[0] |=>
    ledOut[1] == $past(sclk_q) && ledOut[0] == $past(serData_q[0]))
    else $error("Basic serial pins do not carry data and clock");
  chk_ext_off: assert property (extendedLedControl[ledser_pkg::EXT_EN_LSB] &&
    ledMode[3:0] == ledser_pkg::EXT_OFF && !enhMode[0] &&
    !globalLedConfig[ledser_pkg::GCFG_SWAP] |=> ledOut[0] == 1'b0)
    else $error("Extended off mode left LED asserted");
  chk_flf_pin: assert property ($rose(flfNow[0]) |=> fastLinkDownOut[0] ##1 fastLinkDownOut[0]
    || !flfNow[0])
    else $error("Fast link-down pin missed a failure");
  chk_flf_int: assert property ($rose(flfNow[0]) && !spd10[0] |=> intFlag_q[0])
    else $error("Failure at high speed did not raise the interrupt flag");
  chk_int_hold: assert property (intFlag_q[0] && !intStatusClear[0] |=> intFlag_q[0])
    else $error("Interrupt flag dropped without a clear");
  chk_dim_period: assert property (pulseWrap |=> pulseCnt_q == '0 ##1 pulseCnt_q == PW'(1))
    else $error("Dim pulse period counter did not restart");
endmodule : ledser_top

/* testbench/ledser_sipo_model.sv */
// Behavioural serial-to-parallel LED converter on the far side of the LED pins.
// Assumes data and shift clock come from the block; the latch pin is used in enhanced use.
`timescale 1ns/10ps
module ledser_sipo_model #(
  parameter real GAP_NS = 120.0
) (
  // Pins from the block
  input wire logic dataIn,
  input wire logic shiftClk,
  input wire logic latchIn,
  // Use
  input wire logic enhanced,
  // Parallel word seen by the board
  output logic [23:0] frame,
  output logic frameValid,
  output int protoErrs
);
  logic [23:0] shiftReg;
  int bitCount;
  realtime lastRise;
  initial begin
    frame = 24'h000000;
    frameValid = 1'b0;
    protoErrs = 0;
    shiftReg = 24'h000000;
    bitCount = 0;
    lastRise = 0;
  end
  task automatic emit(input logic [23:0] w);
    frame = w;
    frameValid = 1'b1;
    #1 frameValid = 1'b0;
  endtask : emit
  // Data moving while the clock is high would be sampled unreliably
  always @(dataIn) begin
    if (shiftClk === 1'b1)
      protoErrs++;
  end
  // Basic use has no latch pin, so a long clock gap marks the frame start
  always @(posedge shiftClk) begin
    if (!enhanced && ($realtime - lastRise > GAP_NS))
      bitCount = 0;
    lastRise = $realtime;
    shiftReg = {shiftReg[22:0], dataIn};
    bitCount++;
    if (!enhanced && bitCount == 24)
      emit(shiftReg);
  end
  always @(negedge latchIn) begin
    if (enhanced)
      emit({20'h00000, shiftReg[3:0]});
  end
endmodule : ledser_sipo_model

/* testbench/tb_top.sv */
// Self-checking bench for the LED status block, converter models on both ports.
// Assumes shortened timing parameters; every expectation derives from them.
`timescale 1ns/10ps
module tb_top;
  localparam int unsigned PCYC = 100;
  typedef struct {logic src; logic [23:0] val;} ledser_note_type;
  logic clk, nrst, linkClk, ledPulsingEn, intPinEnable, softReset, lowPowerHold;
  logic [1:0] linkUp1000, linkUp100, linkUp10, fullDuplex, collision, txActivity;
  logic [1:0] rxActivity, anegFault, linkIntegrityOk, linkStatusBit, ledRateSel;
  logic [1:0] intStatusClear, fastLinkDownOut, fastLinkFailure;
  logic [1:0] mgmtInterruptNOut, mgmtInterruptNOe;
  logic [31:0] ledMode;
  logic [7:0] ledCombineEn, ledBlinkSel, ledOut;
  logic [15:0] globalLedConfig, extendedLedControl;
  logic [23:0] frame0, frame1;
  logic valid0, valid1;
  logic [7:0] duties [4] = '{8'h00, 8'h40, 8'h80, 8'hff};
  int errs0, errs1, errors, testsRun;
  ledser_note_type notes[$];
  ledser_top #(.TICK_CYC(20), .BAR_CYC(200), .PULSE_CYC(PCYC), .SHIFT_HALF_CYC(4)) uut (
    .clk(clk), .nrst(nrst), .linkClk(linkClk), .linkUp1000(linkUp1000),
    .linkUp100(linkUp100), .linkUp10(linkUp10), .fullDuplex(fullDuplex),
    .collision(collision), .txActivity(txActivity), .rxActivity(rxActivity),
    .anegFault(anegFault), .linkIntegrityOk(linkIntegrityOk), .linkStatusBit(linkStatusBit),
    .ledMode(ledMode), .ledCombineEn(ledCombineEn), .ledBlinkSel(ledBlinkSel),
    .ledRateSel(ledRateSel), .ledPulsingEn(ledPulsingEn), .globalLedConfig(globalLedConfig),
    .extendedLedControl(extendedLedControl), .intPinEnable(intPinEnable),
    .intStatusClear(intStatusClear), .softReset(softReset), .lowPowerHold(lowPowerHold),
    .ledOut(ledOut), .fastLinkDownOut(fastLinkDownOut), .fastLinkFailure(fastLinkFailure),
    .mgmtInterruptNOut(mgmtInterruptNOut), .mgmtInterruptNOe(mgmtInterruptNOe));
  ledser_sipo_model #(.GAP_NS(120.0)) sipo0 (.dataIn(ledOut[0]), .shiftClk(ledOut[1]),
    .latchIn(ledOut[2]), .enhanced(globalLedConfig[1]), .frame(frame0), .frameValid(valid0),
    .protoErrs(errs0));
  ledser_sipo_model #(.GAP_NS(120.0)) sipo1 (.dataIn(ledOut[4]), .shiftClk(ledOut[5]),
    .latchIn(ledOut[6]), .enhanced(1'b1), .frame(frame1), .frameValid(valid1),
    .protoErrs(errs1));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    linkClk = 1'b0;
    #1.7;
    forever #3 linkClk = ~linkClk;
  end
  task automatic miss(input logic [31:0] got, input logic [31:0] exp);
    errors++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
  endtask : miss
  task automatic cmpLevel(input logic [1:0] got, input logic [1:0] exp);
    testsRun++;
    if (got !== exp)
      miss({30'h0, got}, {30'h0, exp});
  endtask : cmpLevel
  task automatic cmpCount(input int got, input int exp);
    testsRun++;
    if (got != exp)
      miss(got, exp);
  endtask : cmpCount
  task automatic cmpFrame(input logic [23:0] got, input logic [23:0] exp);
    testsRun++;
    if (got !== exp)
      miss({8'h00, got}, {8'h00, exp});
  endtask : cmpFrame
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", testsRun, errors);
    if (errors == 0 && testsRun > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  always @(posedge valid0 or posedge valid1) begin
    if (notes.size() > 0 && (notes[0].src ? valid1 : valid0) === 1'b1) begin
      cmpFrame(notes[0].src ? frame1 : frame0, notes[0].val);
      void'(notes.pop_front());
    end
  end
  // Settle first: a frame in flight when the mode changed is garbage
  task automatic checkFrame(input logic src, input logic [23:0] exp);
    int p0;
    repeat (300) @(posedge clk);
    p0 = errs0 + errs1;
    notes.push_back('{src, exp});
    for (int i = 0; i < 1000 && notes.size() > 0; i++)
      @(posedge clk);
    cmpCount(notes.size(), 0);
    cmpCount(errs0 + errs1 - p0, 0);
  endtask : checkFrame
  task automatic highCount(input int idx, output int n);
    n = 0;
    repeat (PCYC) begin
      @(posedge clk);
      n += int'(ledOut[idx] === 1'b1);
    end
  endtask : highCount
  task automatic ledCase(input logic ext, input logic [3:0] base, input logic puls,
      input logic integ, input int exp);
    int n;
    @(posedge clk);
    extendedLedControl <= {3'h0, ext, 12'h000};
    ledMode[3:0] <= base;
    ledPulsingEn <= puls;
    linkIntegrityOk[0] <= integ;
    repeat (PCYC) @(posedge clk);
    highCount(0, n);
    cmpCount(n, exp);
  endtask : ledCase
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    conclude();
  end
  initial begin
    int n;
    logic [3:0] pat;
    errors = 0;
    testsRun = 0;
    nrst = 1'b0;
    {ledPulsingEn, softReset, lowPowerHold, linkUp100, fullDuplex, collision} = '0;
    {txActivity, rxActivity, ledRateSel, intStatusClear, ledCombineEn, ledBlinkSel} = '0;
    {globalLedConfig, extendedLedControl} = '0;
    {intPinEnable, linkUp1000, linkUp10, anegFault} = 7'b1_01_10_10;
    {linkIntegrityOk, linkStatusBit} = 4'hf;
    ledMode = 32'heeeeeeee;
    void'($urandom(69));
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    ledMode <= 32'heeeeeeed;
    globalLedConfig <= 16'h0001;
    checkFrame(1'b0, 24'hc00901);
    @(posedge clk);
    ledMode <= 32'h000e000f;
    repeat (10) @(posedge clk);
    cmpLevel({ledOut[4], ledOut[0]}, 2'b10);
    globalLedConfig <= 16'h0000;
    repeat (10) @(posedge clk);
    cmpLevel({ledOut[4], ledOut[0]}, 2'b01);
    for (int p = 0; p < 2; p++) begin
      pat = 4'($urandom());
      @(posedge clk);
      globalLedConfig <= 16'h0006;
      for (int k = 0; k < 4; k++)
        ledMode[16 * p + 4 * k +: 4] <= pat[3 - k] ? 4'hf : 4'he;
      checkFrame(p[0], {20'h00000, pat});
    end
    foreach (duties[i]) begin
      @(posedge clk);
      globalLedConfig <= {duties[i], 8'h06};
      repeat (PCYC + 5) @(posedge clk);
      highCount(3, n);
      cmpCount(n, int'(duties[i]) * PCYC / 256);
    end
    @(posedge clk);
    globalLedConfig <= 16'h0000;
    txActivity <= 2'b01;
    ledCase(1'b1, 4'h4, 1'b1, 1'b1, 0);
    ledCase(1'b1, 4'h5, 1'b1, 1'b1, PCYC);
    ledCase(1'b1, 4'h6, 1'b0, 1'b0, PCYC);
    ledCase(1'b1, 4'h6, 1'b0, 1'b1, 0);
    ledCase(1'b0, 4'hf, 1'b1, 1'b1, PCYC * 20 / 100);
    ledCase(1'b0, 4'h1, 1'b0, 1'b1, PCYC);
    // Combine with blink: tx activity turns the steady link into a 40-cycle blink
    ledCombineEn <= 8'h01;
    ledBlinkSel <= 8'h01;
    repeat (PCYC) @(posedge clk);
    highCount(0, n);
    cmpCount(int'(n >= 40 && n <= 60), 1);
    ledCombineEn <= 8'h00;
    extendedLedControl <= 16'h0800;
    // Blink window after hold release, then after software reset
    for (int r = 0; r < 2; r++) begin
      lowPowerHold <= r == 0;
      softReset <= r == 1;
      @(posedge clk);
      {lowPowerHold, softReset} <= 2'b00;
      repeat (5) @(posedge clk);
      highCount(0, n);
      cmpCount(int'(n >= 40 && n <= 60), 1);
      repeat (PCYC + 20) @(posedge clk);
      highCount(0, n);
      cmpCount(n, PCYC);
    end
    for (int s = 0; s < 3; s++) begin
      @(posedge clk);
      {linkUp1000[0], linkUp100[0], linkUp10[0]} <= 3'b100 >> s;
      intStatusClear <= 2'b01;
      @(posedge clk);
      intStatusClear <= 2'b00;
      repeat (20) @(posedge clk);
      cmpLevel(fastLinkFailure, 2'b00);
      if (s == 0)
        linkIntegrityOk[0] <= 1'b0;
      else
        linkStatusBit[0] <= 1'b0;
      for (n = 0; n < 30 && fastLinkDownOut[0] !== 1'b1; n++)
        @(posedge clk);
      cmpCount(int'(n < 12), 1);
      @(posedge clk);
      cmpLevel(fastLinkFailure, {1'b0, s != 2});
      cmpLevel(mgmtInterruptNOe, {1'b0, s != 2});
      cmpLevel(mgmtInterruptNOut, 2'b00);
      linkIntegrityOk[0] <= 1'b1;
      linkStatusBit[0] <= 1'b1;
      intPinEnable <= 1'b0;
      repeat (20) @(posedge clk);
      cmpLevel({fastLinkDownOut[0], fastLinkFailure[0]}, {1'b0, s != 2});
      cmpLevel(mgmtInterruptNOe, 2'b00);
      intPinEnable <= 1'b1;
      repeat (3) @(posedge clk);
      cmpLevel(mgmtInterruptNOe, {1'b0, s != 2});
    end
    conclude();
  end
endmodule : tb_top
